// ---- design/mioa_pkg.sv ----
package mioa_pkg;

  // ****************************************
  // Word and field layout
  // ****************************************
  localparam int DATA_W = 32;
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int RD_MSB = 25;
  localparam int RD_LSB = 20;
  localparam int MEM_UPDATE_BIT = 19;
  localparam int ABC_MSB = 18;
  localparam int ABC_LSB = 16;
  localparam int RSA_MSB = 15;
  localparam int RSA_LSB = 10;
  localparam int IMM_MSB = 9;
  localparam int IMM_LSB = 0;
  localparam int IMM_W = 10;
  localparam int MOD_MSB = 9;
  localparam int MOD_LSB = 7;
  localparam int ALWAYS_EXEC_BIT = 6;
  localparam int RSB_MSB = 5;
  localparam int RSB_LSB = 0;
  localparam int REG_IDX_W = 6;
  localparam int ABC_W = 3;
  localparam int MOD_W = 3;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [5:0] OPC_MIN_IMM = 6'h3D;
  localparam logic [5:0] OPC_OR_REG = 6'h31;

  // ****************************************
  // Modulo window: bits per modulo step
  // ****************************************
  localparam int MOD_STEP = 4;

  // ****************************************
  // Branch conditions
  // ****************************************
  typedef enum logic [2:0] {
    MIOA_C_NEVER = 3'h0,
    MIOA_C_ALWAYS = 3'h1,
    MIOA_C_ZERO = 3'h2,
    MIOA_C_NONZERO = 3'h3,
    MIOA_C_SEL4 = 3'h4,
    MIOA_C_SEL5 = 3'h5,
    MIOA_C_OVF = 3'h6,
    MIOA_C_NOOVF = 3'h7
  } mioa_cond_t;

  localparam logic [DATA_W-1:0] RESET_DATA = 32'h0000_0000;

endpackage : mioa_pkg

// ---- design/mioa_cond_eval.sv ----
module mioa_cond_eval
  import mioa_pkg::*;
(
  input wire logic [DATA_W-1:0] result_i,
  input wire logic [DATA_W-1:0] opa_i,
  input wire logic alt_set_i,
  input wire logic [ABC_W-1:0] abc_i,
  input wire logic ovf_i,
  output logic take_o
);

  // ****************************************
  // Condition decode
  // ****************************************
  // Codes 4 and 5 differ per set: sign test by default, operand kept in the alternate set
  always_comb begin
    take_o = 1'b0;
    unique case (mioa_cond_t'(abc_i))
      MIOA_C_NEVER: take_o = 1'b0;
      MIOA_C_ALWAYS: take_o = 1'b1;
      MIOA_C_ZERO: take_o = (result_i == RESET_DATA);
      MIOA_C_NONZERO: take_o = (result_i != RESET_DATA);
      MIOA_C_SEL4: take_o = alt_set_i ? (result_i == opa_i) : result_i[DATA_W-1];
      MIOA_C_SEL5: take_o = alt_set_i ? (result_i != opa_i) : !result_i[DATA_W-1];
      MIOA_C_OVF: take_o = ovf_i;
      MIOA_C_NOOVF: take_o = !ovf_i;
    endcase
  end

endmodule : mioa_cond_eval

// ---- design/mioa_alu.sv ----
// Operation
// RL1: Decode opcode 111101 with register/immediate fields
// RL2: Extend immediate bit 9 through bits 31:10
// RL3: Unsigned minimum of rsa and immediate to rd
// RL4: Overflow flag left unchanged by both operations
// RL5: Minimum-immediate uses alternate branch condition set
// RL6: Decode opcode 110001 with two-register fields
// RL7: OR rsa with rsb under modulo select
// RL8: Branch on condition of ALU result
// RL9: Update bit writes result to Fast Memory
module mioa_alu
  import mioa_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic valid_i,
  input wire logic [DATA_W-1:0] insn_i,
  input wire logic [DATA_W-1:0] opa_i,
  input wire logic [DATA_W-1:0] opb_i,
  input wire logic ovf_i,
  output logic wb_valid_o,
  output logic [REG_IDX_W-1:0] wb_rd_o,
  output logic [DATA_W-1:0] wb_data_o,
  output logic mem_update_o,
  output logic branch_take_o,
  output logic always_exec_o,
  output logic ovf_flag_o,
  output logic unknown_op_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic wb_valid;
    logic [REG_IDX_W-1:0] wb_rd;
    logic [DATA_W-1:0] wb_data;
    logic mem_update;
    logic branch_take;
    logic always_exec;
    logic ovf_flag;
    logic unknown_op;
  } mioa_state_t;

  mioa_state_t state_reg;
  mioa_state_t state_next;

  // ****************************************
  // Decode and datapath
  // ****************************************
  logic [5:0] opcode;
  logic is_min_imm;
  logic is_or_reg;
  logic [DATA_W-1:0] imm_ext;
  logic [DATA_W-1:0] min_val;
  logic [DATA_W-1:0] or_val;
  logic [DATA_W-1:0] mod_mask;
  logic [DATA_W-1:0] result;
  logic [MOD_W-1:0] modulo_select;
  logic cond_take;

  assign opcode = insn_i[OPC_MSB:OPC_LSB];
  assign is_min_imm = (opcode == OPC_MIN_IMM); // RL1
  assign is_or_reg = (opcode == OPC_OR_REG); // RL6
  assign modulo_select = insn_i[MOD_MSB:MOD_LSB];
  assign imm_ext = {{(DATA_W-IMM_W){insn_i[IMM_MSB]}}, insn_i[IMM_MSB:IMM_LSB]}; // RL2
  assign min_val = (opa_i < imm_ext) ? opa_i : imm_ext; // RL3

  // Modulo window: a nonzero modulo_select changes only the low bits, upper bits keep rsa
  always_comb begin
    mod_mask = '1;
    if (modulo_select != '0) begin
      mod_mask = ~({DATA_W{1'b1}} << (int'(modulo_select) * MOD_STEP));
    end
  end

  assign or_val = ((opa_i | opb_i) & mod_mask) | (opa_i & ~mod_mask); // RL7
  assign result = is_min_imm ? min_val : or_val;

  mioa_cond_eval u_cond (
    .result_i(result),
    .opa_i(opa_i),
    .alt_set_i(is_min_imm), // RL5
    .abc_i(insn_i[ABC_MSB:ABC_LSB]),
    .ovf_i(ovf_i),
    .take_o(cond_take)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.ovf_flag = ovf_i; // RL4
    state_next.wb_valid = 1'b0;
    state_next.mem_update = 1'b0;
    state_next.branch_take = 1'b0;
    state_next.always_exec = 1'b0;
    state_next.unknown_op = 1'b0;
    if (valid_i) begin
      if (is_min_imm || is_or_reg) begin
        state_next.wb_valid = 1'b1;
        state_next.wb_rd = insn_i[RD_MSB:RD_LSB];
        state_next.wb_data = result;
        state_next.mem_update = insn_i[MEM_UPDATE_BIT]; // RL9
        state_next.branch_take = cond_take; // RL8
        // Immediate form has no always-execute bit; its low bits are data
        state_next.always_exec = is_or_reg && insn_i[ALWAYS_EXEC_BIT];
      end else begin
        // Foreign opcodes are flagged, never written back
        state_next.unknown_op = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_valid_o = state_reg.wb_valid;
  assign wb_rd_o = state_reg.wb_rd;
  assign wb_data_o = state_reg.wb_data;
  assign mem_update_o = state_reg.mem_update;
  assign branch_take_o = state_reg.branch_take;
  assign always_exec_o = state_reg.always_exec;
  assign ovf_flag_o = state_reg.ovf_flag;
  assign unknown_op_o = state_reg.unknown_op;

  // ****************************************
  // Assertions
  // ****************************************
  a_decode_min_hit: assert property ( // RL1
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[OPC_MSB:OPC_LSB] == 6'h3D
    |=> wb_valid_o && !unknown_op_o && wb_rd_o == $past(insn_i[25:20]))
    else $error("min-immediate not decoded");

  a_decode_or_hit: assert property ( // RL6
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[OPC_MSB:OPC_LSB] == 6'h31
    |=> wb_valid_o && always_exec_o == $past(insn_i[6]))
    else $error("register OR not decoded");

  a_decode_foreign: assert property ( // RL1
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[31:26] != 6'h3D && insn_i[31:26] != 6'h31
    |=> !wb_valid_o && unknown_op_o && !mem_update_o && !branch_take_o)
    else $error("foreign opcode wrote back");

  a_imm_extend: assert property ( // RL2
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[31:26] == 6'h3D
    |=> $past(insn_i[9])
        ? (wb_data_o == $past(opa_i) || wb_data_o[31:10] == 22'h3FFFFF)
        : wb_data_o[31:9] == 23'h0)
    else $error("immediate not extended from bit 9");

  a_min_value: assert property ( // RL3
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[31:26] == 6'h3D
    |=> (wb_data_o == $past(opa_i) || wb_data_o == $past(imm_ext))
        && wb_data_o <= $past(opa_i) && wb_data_o <= $past(imm_ext))
    else $error("minimum wrong");

  a_ovf_kept: assert property ( // RL4
    @(posedge clock_i) disable iff (!reset_n_i)
    $past(valid_i) && $past(reset_n_i) |-> ovf_flag_o == $past(ovf_i))
    else $error("overflow flag altered");

  a_alt_cond_set: assert property ( // RL5
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[31:26] == 6'h3D && insn_i[18:16] == 3'h4
    |=> branch_take_o == (wb_data_o == $past(opa_i)))
    else $error("alternate condition set not used");

  a_or_value: assert property ( // RL7
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[31:26] == 6'h31
    |=> (wb_data_o & ~($past(opa_i) | $past(opb_i))) == 32'h0000_0000
        && ($past(insn_i[9:7]) != 3'h0 || wb_data_o == ($past(opa_i) | $past(opb_i))))
    else $error("OR result wrong");

  a_branch_fixed: assert property ( // RL8
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && (insn_i[31:26] == 6'h3D || insn_i[31:26] == 6'h31)
    |=> branch_take_o == ($past(insn_i[18:16]) == 3'h1
        || ($past(insn_i[18:16]) == 3'h2 && wb_data_o == 32'h0000_0000)
        || ($past(insn_i[18:16]) == 3'h3 && wb_data_o != 32'h0000_0000)
        || ($past(insn_i[18:16]) == 3'h6 && ovf_flag_o)
        || ($past(insn_i[18:16]) == 3'h7 && !ovf_flag_o)
        || ($past(insn_i[18:16]) == 3'h4
            && ($past(insn_i[31:26]) == 6'h3D ? wb_data_o == $past(opa_i) : wb_data_o[31]))
        || ($past(insn_i[18:16]) == 3'h5
            && ($past(insn_i[31:26]) == 6'h3D ? wb_data_o != $past(opa_i) : !wb_data_o[31]))))
    else $error("branch condition wrong");

  a_mem_update: assert property ( // RL9
    @(posedge clock_i) disable iff (!reset_n_i)
    mem_update_o |-> wb_valid_o && $past(insn_i[19]))
    else $error("memory update without update bit");

  a_idle_quiet: assert property ( // RL9
    @(posedge clock_i) disable iff (!reset_n_i)
    !valid_i
    |=> !wb_valid_o && !mem_update_o && !branch_take_o && !always_exec_o && !unknown_op_o)
    else $error("result pulse without instruction");

  a_update_bit: assert property ( // RL9
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && (insn_i[31:26] == 6'h3D || insn_i[31:26] == 6'h31)
    |=> mem_update_o == $past(insn_i[19]))
    else $error("update bit not followed");

  a_min_no_exec: assert property ( // RL1
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[31:26] == 6'h3D
    |=> !always_exec_o)
    else $error("immediate bits read as always-execute");

  a_or_mod_window: assert property ( // RL7
    @(posedge clock_i) disable iff (!reset_n_i)
    valid_i && insn_i[31:26] == 6'h31 && insn_i[9:7] != 3'h0
    |=> ((wb_data_o ^ $past(opa_i)) >> (MOD_STEP * $past(insn_i[9:7]))) == 32'h0000_0000)
    else $error("modulo window leaked into upper bits");

endmodule : mioa_alu

// ---- dv/mioa_rf_model.sv ----
module mioa_rf_model
  import mioa_pkg::*;
(
  input wire logic clock_i,
  input wire logic valid_i,
  input wire logic [DATA_W-1:0] insn_i,
  input wire logic wb_valid_i,
  input wire logic [REG_IDX_W-1:0] wb_rd_i,
  input wire logic [DATA_W-1:0] wb_data_i,
  output logic [DATA_W-1:0] opa_o,
  output logic [DATA_W-1:0] opb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Register file seen by the block
  // ****
  logic [DATA_W-1:0] regs [64];
  initial begin
    for (int i = 0; i < 64; i++) begin
      regs[i] = 32'(i) << i[4:0];
    end
  end
  // Idle cycles show inverted data, so a stale operand cannot pass
  assign opa_o = valid_i ? regs[insn_i[15:10]] : ~regs[insn_i[15:10]];
  assign opb_o = valid_i ? regs[insn_i[5:0]] : ~regs[insn_i[5:0]];
  always @(posedge clock_i) begin
    if (wb_valid_i) begin
      regs[wb_rd_i] <= wb_data_i;
    end
  end
endmodule : mioa_rf_model

// ---- dv/testbench.sv ----
module testbench
  import mioa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic valid_i = 1'b0;
  logic ovf_i = 1'b0;
  logic [31:0] insn_i = 32'h0;
  logic [31:0] opa, opb, wb_data_o, s = 32'h0001_3352, w, rn;
  logic [5:0] wb_rd_o, ef = 6'h0, er = 6'h0;
  logic [31:0] ed = 32'h0;
  logic wb_valid_o, mem_update_o, branch_take_o, always_exec_o, ovf_flag_o, unknown_op_o;
  logic [31:0] m [64];
  int n_errors = 0;
  int checked = 0;
  always #20 clock_i = ~clock_i;
  mioa_alu dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .valid_i(valid_i),
    .insn_i(insn_i), .opa_i(opa), .opb_i(opb), .ovf_i(ovf_i), .wb_valid_o(wb_valid_o),
    .wb_rd_o(wb_rd_o), .wb_data_o(wb_data_o), .mem_update_o(mem_update_o),
    .branch_take_o(branch_take_o), .always_exec_o(always_exec_o),
    .ovf_flag_o(ovf_flag_o), .unknown_op_o(unknown_op_o));
  mioa_rf_model u_rf (.clock_i(clock_i), .valid_i(valid_i), .insn_i(insn_i),
    .wb_valid_i(wb_valid_o), .wb_rd_i(wb_rd_o), .wb_data_i(wb_data_o),
    .opa_o(opa), .opb_o(opb));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [5:0] flg();
    return {wb_valid_o, mem_update_o, branch_take_o, always_exec_o, ovf_flag_o, unknown_op_o};
  endfunction : flg
  // Checks the previous word's result, then issues the next one
  task automatic op(input logic v, input logic [31:0] x, input logic f);
    logic [31:0] a, b, imm, mk, r;
    logic mn, orr, c;
    a = m[x[15:10]];
    b = m[x[5:0]];
    chk("flags", 32'(flg()), 32'(ef));
    chk("rd", 32'(wb_rd_o), 32'(er));
    chk("data", wb_data_o, ed);
    if (ef[5]) m[er] = ed;
    mn = v && x[31:26] == OPC_MIN_IMM;
    orr = v && x[31:26] == OPC_OR_REG;
    imm = {{22{x[9]}}, x[9:0]};
    mk = (32'h1 << (MOD_STEP * x[9:7])) - 32'h1;
    r = orr ? (x[9:7] == 3'h0 ? a | b : a | (b & mk)) : (a < imm ? a : imm);
    case (x[18:16])
      3'h0: c = 1'b0;
      3'h1: c = 1'b1;
      3'h2: c = r == 32'h0;
      3'h3: c = r != 32'h0;
      3'h4: c = mn ? r == a : r[31];
      3'h5: c = mn ? r != a : !r[31];
      3'h6: c = f;
      default: c = !f;
    endcase
    ef = {mn | orr, (mn | orr) & x[19], (mn | orr) & c, orr & x[6], f, v & !(mn | orr)};
    if (mn | orr) begin
      er = x[25:20];
      ed = r;
    end
    valid_i = v;
    insn_i = x;
    ovf_i = f;
    @(posedge clock_i);
    #1;
  endtask : op
  // ****
  // Sequence
  // ****
  initial begin
    for (int i = 0; i < 64; i++) begin
      m[i] = 32'(i) << i[4:0];
    end
    repeat (8) @(posedge clock_i);
    #1;
    chk("reset", 32'(flg()), 32'h0);
    reset_n_i = 1'b1;
    // Alternate condition set differs from default here
    op(1'b1, {OPC_MIN_IMM, 6'h05, 1'b1, 3'h4, 6'h01, 10'h010}, 1'b1);
    op(1'b1, {OPC_MIN_IMM, 6'h06, 1'b0, 3'h5, 6'h03, 10'h3FF}, 1'b0);
    op(1'b1, {OPC_OR_REG, 6'h3F, 1'b0, 3'h3, 6'h02, 3'h7, 1'b1, 6'h3F}, 1'b1);
    repeat (400) begin
      rn = xs();
      w = xs();
      if (rn[1:0] != 2'h0) w[31:26] = rn[2] ? OPC_MIN_IMM : OPC_OR_REG;
      op(rn[4:3] != 2'h0, w, rn[8]);
    end
    op(1'b0, 32'h0, 1'b0);
    summarize();
  end
  // Run needs about 420 cycles
  initial begin
    #(40 * 5000);
    n_errors++;
    summarize();
  end
endmodule : testbench
